// ---- shared/fsus_pkg.sv ----
package fsus_pkg;
	// register indices, byte address is four times the index
	localparam logic [11:0] IDX_SUMMARY  = 12'h52d;
	localparam logic [11:0] IDX_UART     = 12'h530;
	localparam logic [11:0] IDX_MASK     = 12'h540;
	localparam logic [11:0] IDX_UART_CLR = 12'h541;
	localparam logic [11:0] IDX_IRQ_STAT = 12'h542;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h543;
	// index field inside haddr
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 13;
	// fault source widths in bits
	localparam int PROT_W  = 16;
	localparam int COMP_W  = 80;
	localparam int BYTE_W  = 8;
	localparam int HBT_W   = 4;
	localparam int CELL_W  = 16;
	localparam int PWR_W   = 24;
	// mask register fields
	localparam int MSK_W     = 14;
	localparam int M_PROT    = 0;
	localparam int M_COMP    = 1;
	localparam int M_OTP     = 2;
	localparam int M_UART    = 3;
	localparam int M_CHAIN   = 4;
	localparam int M_HB      = 5;
	localparam int M_TONE    = 6;
	localparam int M_UPSTRM  = 7;
	localparam int M_OT      = 8;
	localparam int M_UT      = 9;
	localparam int M_OV      = 10;
	localparam int M_UV      = 11;
	localparam int M_SYS     = 12;
	localparam int M_PWR     = 13;
	// summary byte fields
	localparam int S_PROT = 7;
	localparam int S_COMP = 6;
	localparam int S_OTP  = 5;
	localparam int S_COMM = 4;
	localparam int S_TEMP = 3;
	localparam int S_VOLT = 2;
	localparam int S_SYS  = 1;
	localparam int S_PWR  = 0;
	// heartbeat and tone status fields
	localparam int H_FAST  = 0;
	localparam int H_MISS  = 1;
	localparam int H_TONE  = 2;
	localparam int H_UPSTR = 3;
	// uart status fields
	localparam int UST_W    = 5;
	localparam int U_TX     = 4;
	localparam int U_RXRSP  = 3;
	localparam int U_RXCMD  = 2;
	localparam int U_CLEAR  = 1;
	localparam int U_STOP   = 0;
	// interrupt status: uart events plus a summary rise
	localparam int IRQ_W    = 6;
	localparam int I_SUMM   = 5;
	// reset values
	localparam logic [MSK_W-1:0] MASK_RST = 14'h0000;
	localparam logic [UST_W-1:0] UST_RST  = 5'h00;
	localparam logic [IRQ_W-1:0] IRQ_RST  = 6'h00;
	localparam logic [31:0]      WORD_RST = 32'h0000_0000;
	localparam logic [11:0]      IDX_RST  = 12'h000;
	// power mode of the device
	typedef enum logic [1:0] {FSUS_ACTIVE, FSUS_SLEEP, FSUS_SHUTDOWN} fsus_mode_t;
	// bus data phase in progress
	typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} fsus_phase_t;
endpackage

// ---- shared/fsus_flag_if.sv ----
`timescale 1ns/10ps
interface fsus_flag_if;
	import fsus_pkg::*;
	logic [MSK_W-1:0]  mask;
	logic [PROT_W-1:0] prot;
	logic [COMP_W-1:0] comp;
	logic [BYTE_W-1:0] otp;
	logic [BYTE_W-1:0] chain;
	logic [HBT_W-1:0]  hbt;
	logic [CELL_W-1:0] ot;
	logic [CELL_W-1:0] ut;
	logic [CELL_W-1:0] ov;
	logic [CELL_W-1:0] uv;
	logic [BYTE_W-1:0] sys;
	logic [PWR_W-1:0]  pwr;
	logic [UST_W-1:0]  ev;
	logic              ping;
	logic              wake;
	fsus_mode_t        mode;
	logic [UST_W-1:0]  clr;
	logic [UST_W-1:0]  status;
	logic [UST_W-1:0]  set;
	logic [BYTE_W-1:0] summary;
	modport summ (input mask, prot, comp, otp, chain, hbt, ot, ut, ov, uv, sys, pwr,
		status, output summary);
	modport flags (input ev, ping, wake, mode, clr, output status, set);
endinterface

// ---- src/fsus_summary.sv ----
`timescale 1ns/10ps
module fsus_summary
	import fsus_pkg::*;
(
	// sources and masks in, summary byte out
	fsus_flag_if.summ s
);
	// masks are active high: a set mask bit hides its group
	function automatic logic hit(input logic msk, input logic any);
		return !msk && any;
	endfunction

	// purely combinational so each bit follows its sources (see [RULE17])
	always_comb begin
		s.summary[S_PROT] = hit(s.mask[M_PROT], |s.prot);
		s.summary[S_COMP] = hit(s.mask[M_COMP], |s.comp); // see [RULE1]
		s.summary[S_OTP]  = hit(s.mask[M_OTP], |s.otp); // see [RULE2]
		// see [RULE3]
		s.summary[S_COMM] = hit(s.mask[M_UART], |s.status)
			|| hit(s.mask[M_CHAIN], |s.chain)
			|| hit(s.mask[M_HB], s.hbt[H_FAST] || s.hbt[H_MISS]) // see [RULE4]
			|| hit(s.mask[M_TONE], s.hbt[H_TONE])
			|| hit(s.mask[M_UPSTRM], s.hbt[H_UPSTR]);
		s.summary[S_TEMP] = hit(s.mask[M_OT], |s.ot)
			|| hit(s.mask[M_UT], |s.ut); // see [RULE5]
		s.summary[S_VOLT] = hit(s.mask[M_OV], |s.ov)
			|| hit(s.mask[M_UV], |s.uv); // see [RULE6]
		s.summary[S_SYS]  = hit(s.mask[M_SYS], |s.sys); // see [RULE7]
		s.summary[S_PWR]  = hit(s.mask[M_PWR], |s.pwr); // see [RULE8]
	end
endmodule

// ---- src/fsus_uart_flags.sv ----
`timescale 1ns/10ps
module fsus_uart_flags
	import fsus_pkg::*;
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// events in, sticky flags out
	fsus_flag_if.flags f
);
	// whole state of this module
	typedef struct packed {
		logic [UST_W-1:0] status; // sticky uart fault flags
	} fsus_flag_st_t;

	fsus_flag_st_t st;      // registered state
	fsus_flag_st_t next_st; // next state
	logic [UST_W-1:0] setv; // this cycle's set terms

	// set terms per flag
	always_comb begin
		setv          = f.ev;
		setv[U_TX]    = f.ev[U_TX]; // see [RULE9]
		setv[U_RXRSP] = f.ev[U_RXRSP]; // see [RULE10]
		setv[U_RXCMD] = f.ev[U_RXCMD]; // see [RULE11]
		// clear signal, or ping when awake or asleep, or wake pin when active
		setv[U_CLEAR] = f.ev[U_CLEAR] // see [RULE12]
			|| (f.ping && (f.mode == FSUS_ACTIVE || f.mode == FSUS_SLEEP)) // see [RULE13]
			|| (f.wake && f.mode == FSUS_ACTIVE);
		// a ping while already active counts as a stray stop
		setv[U_STOP]  = f.ev[U_STOP] // see [RULE14]
			|| (f.ping && f.mode == FSUS_ACTIVE); // see [RULE15]
	end

	// set wins over a same-cycle clear so no event is lost
	always_comb begin
		next_st        = st;
		next_st.status = (st.status & ~f.clr) | setv;
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '{status: UST_RST};
		end else begin
			st <= next_st;
		end
	end

	assign f.status = st.status;
	assign f.set    = setv;
endmodule

// ---- src/fsus_top.sv ----
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Behaviour
// [RULE1] adc compare bit: unmasked and any compare fault
// [RULE2] nvm bit: unmasked and any nvm fault
// [RULE3] comm bit: unmasked uart or chain faults
// [RULE4] comm bit: heartbeat, tone, upstream each masked
// [RULE5] temperature bit: unmasked over or under fault
// [RULE6] voltage bit: unmasked over or under fault
// [RULE7] system bit: unmasked and any system fault
// [RULE8] power bit: unmasked and any rail fault
// [RULE9] bit 4 set on response transmit error
// [RULE10] bit 3 set on response receive error
// [RULE11] bit 2 set on command receive error
// [RULE12] bit 1 set on link clear signal
// [RULE13] bit 1 also on ping or wake; code takes ping only in active or sleep mode, wake only in active mode
// [RULE14] bit 0 set on unexpected stop
// [RULE15] bit 0 also on ping while active
// [RULE16] summary register mirrors the fault pin
// [RULE17] summary bits follow sources and masks continuously
module fsus_top
	import fsus_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// fault detector status inputs, level
	input  wire logic [PROT_W-1:0] prot_fault,
	input  wire logic [COMP_W-1:0] adc_compare_fault,
	input  wire logic [BYTE_W-1:0] nvm_fault,
	input  wire logic [BYTE_W-1:0] chain_link_fault_status,
	input  wire logic [HBT_W-1:0]  heartbeat_tone_status,
	input  wire logic [CELL_W-1:0] over_temp_fault,
	input  wire logic [CELL_W-1:0] under_temp_fault,
	input  wire logic [CELL_W-1:0] over_volt_fault,
	input  wire logic [CELL_W-1:0] under_volt_fault,
	input  wire logic [BYTE_W-1:0] system_fault,
	input  wire logic [PWR_W-1:0]  power_rail_fault,
	// host uart event pulses
	input  wire logic              tx_response_error,
	input  wire logic              rx_response_error,
	input  wire logic              rx_command_error,
	input  wire logic              link_clear_seen,
	input  wire logic              unexpected_stop_seen,
	input  wire logic              sleep_exit_ping,
	input  wire logic              wake_seen,
	input  wire fsus_mode_t        dev_mode,
	// fault pin and interrupt
	output logic                   fault_output_pin_n,
	output logic                   irq
);

	// whole state of the top module
	typedef struct packed {
		fsus_phase_t      phase;    // pending data phase
		logic [11:0]      idx;      // index taken at the address phase
		logic [31:0]      rdata;    // read data for the data phase
		logic [MSK_W-1:0] mask;     // summary group masks
		logic [UST_W-1:0] uclr;     // one-cycle clear of uart flags
		logic [IRQ_W-1:0] irq_stat; // sticky interrupt events
		logic [IRQ_W-1:0] irq_mask; // interrupt enables
		logic             fault;    // registered any-summary level
	} fsus_top_st_t;

	localparam fsus_top_st_t ST_RST = '{
		phase:    PH_IDLE,
		idx:      IDX_RST,
		rdata:    WORD_RST,
		mask:     MASK_RST,
		uclr:     UST_RST,
		irq_stat: IRQ_RST,
		irq_mask: IRQ_RST,
		fault:    1'b0
	};

	fsus_top_st_t st;      // registered state
	fsus_top_st_t next_st; // next state

	// channel to the two helper blocks
	fsus_flag_if fl ();

	logic              take;   // address phase accepted this edge
	logic [IRQ_W-1:0]  events; // interrupt events this cycle
	logic              any;    // any summary bit set now

	// address decode, used for reads and writes alike
	function automatic logic reg_hit(input logic [31:0] a, input logic [11:0] idx);
		return (a[31:IDX_MSB+1] == '0) && (a[IDX_MSB:IDX_LSB] == idx);
	endfunction

	// zero-extend a byte-wide register into a bus word
	function automatic logic [31:0] word8(input logic [BYTE_W-1:0] b);
		return {24'h00_0000, b};
	endfunction

	// ------------------------------------------------------------
	// sources into the helper blocks
	// ------------------------------------------------------------

	// fault levels and masks feed the summary logic
	assign fl.mask  = st.mask;
	assign fl.prot  = prot_fault;
	assign fl.comp  = adc_compare_fault;
	assign fl.otp   = nvm_fault;
	assign fl.chain = chain_link_fault_status;
	assign fl.hbt   = heartbeat_tone_status;
	assign fl.ot    = over_temp_fault;
	assign fl.ut    = under_temp_fault;
	assign fl.ov    = over_volt_fault;
	assign fl.uv    = under_volt_fault;
	assign fl.sys   = system_fault;
	assign fl.pwr   = power_rail_fault;

	// uart events, packed in status bit order
	assign fl.ev = {tx_response_error, rx_response_error, rx_command_error,
		link_clear_seen, unexpected_stop_seen};
	assign fl.ping = sleep_exit_ping;
	assign fl.wake = wake_seen;
	assign fl.mode = dev_mode;
	assign fl.clr  = st.uclr;

	// summary byte, combinational from sources
	fsus_summary u_summary (
		.s (fl.summ)
	);

	// sticky uart flags
	fsus_uart_flags u_flags (
		.hclk    (hclk),
		.hresetn (hresetn),
		.f       (fl.flags)
	);

	// ------------------------------------------------------------
	// bus and register logic
	// ------------------------------------------------------------

	// a transfer is taken on nonseq or seq with the bus ready
	assign take = hsel && htrans[1] && hready;

	// any summary bit drives the fault pin
	assign any = |fl.summary;

	// interrupt sources: every uart flag set plus a new summary fault
	assign events = {any && !st.fault, fl.set};

	// next-state logic for the whole module
	always_comb begin
		next_st = st;
		// clear pulses last one cycle only
		next_st.uclr = UST_RST;
		// the pin level is one cycle behind the summary byte (see [RULE16])
		next_st.fault = any;

		// write data phase: hwdata stands now, apply it at this edge
		if (st.phase == PH_WRITE) begin
			unique case (st.idx)
				IDX_MASK: begin
					// masks steer the summary groups
					next_st.mask = hwdata[MSK_W-1:0];
				end
				IDX_UART_CLR: begin
					// write one clears the matching uart flag
					next_st.uclr = hwdata[UST_W-1:0];
				end
				IDX_IRQ_STAT: begin
					// write one clears, applied before new events below
					next_st.irq_stat = st.irq_stat & ~hwdata[IRQ_W-1:0];
				end
				IDX_IRQ_MASK: begin
					// a one enables that status bit onto irq
					next_st.irq_mask = hwdata[IRQ_W-1:0];
				end
				default: begin
					// read-only or unmapped: write is dropped, answer stays okay
				end
			endcase
		end

		// new events win over a clear in the same cycle
		next_st.irq_stat = next_st.irq_stat | events;

		// address phase: capture target and prepare read data
		if (take) begin
			next_st.idx   = haddr[IDX_MSB:IDX_LSB];
			next_st.phase = hwrite ? PH_WRITE : PH_READ;
			next_st.rdata = WORD_RST;
			if (!hwrite) begin
				// mask and irq reads see the value after any write of this edge; summary and uart reads see the value before it
				if (reg_hit(haddr, IDX_SUMMARY)) begin
					// software copy of the fault pin source (see [RULE16])
					next_st.rdata = word8(fl.summary);
				end else if (reg_hit(haddr, IDX_UART)) begin
					// sticky uart flags, upper bits reserved as zero
					next_st.rdata = {27'h000_0000, fl.status};
				end else if (reg_hit(haddr, IDX_MASK)) begin
					next_st.rdata = {18'h0_0000, next_st.mask};
				end else if (reg_hit(haddr, IDX_IRQ_STAT)) begin
					next_st.rdata = {26'h000_0000, next_st.irq_stat};
				end else if (reg_hit(haddr, IDX_IRQ_MASK)) begin
					next_st.rdata = {26'h000_0000, next_st.irq_mask};
				end else begin
					// clear register and unmapped words read as zero
					next_st.rdata = WORD_RST;
				end
			end
			if (!reg_hit(haddr, haddr[IDX_MSB:IDX_LSB])) begin
				// outside the window: keep no write pending
				next_st.phase = PH_IDLE;
			end
		end else begin
			// no transfer: nothing pending for the next cycle
			next_st.phase = PH_IDLE;
		end
	end

	// state register, constant values under reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------

	// zero wait states: every data phase completes in one cycle
	assign hreadyout = 1'b1;

	// always okay; unmapped words just read zero
	assign hresp = 1'b0;

	// read data comes straight from its register
	assign hrdata = st.rdata;

	// fault pin is active low while any summary bit is set
	assign fault_output_pin_n = !st.fault;

	// level interrupt, high while any enabled status bit is set
	assign irq = |(st.irq_stat & st.irq_mask);

	// hsize is not checked: only whole-word transfers are expected,
	// a narrower write still lands in the low bits of the word
	logic unused_hsize;
	assign unused_hsize = ^hsize;

endmodule

// ---- bench/fsus_host_model.sv ----
`timescale 1ns/10ps
// host side ahb-lite master; tolerates wait states, always waits on hready
module fsus_host_model
	import fsus_pkg::*;
(
	// clock
	input  wire logic        hclk,
	// request
	output logic             hsel,
	output logic             hwrite,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// answer
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	// idle bus, whole words only
	initial begin
		hsel   = 1'b0;
		hwrite = 1'b0;
		haddr  = WORD_RST;
		htrans = 2'b00;
		hsize  = 3'h2;
		hwdata = WORD_RST;
	end
	// one single transfer; stale write data is inverted so nothing leans on it
	task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		hwrite <= w;
		haddr  <= {18'h0, i, 2'b00};
		htrans <= 2'b10;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
endmodule

// ---- bench/fsus_top_assertions.sv ----
`timescale 1ns/10ps
// the mask register is shadowed by snooping bus writes, since it has no port
module fsus_top_chk
	import fsus_pkg::*;
(
	// clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// register bus
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	input wire logic [31:0]       hrdata,
	// fault sources
	input wire logic [COMP_W-1:0] adc_compare_fault,
	input wire logic [BYTE_W-1:0] nvm_fault,
	input wire logic [HBT_W-1:0]  heartbeat_tone_status,
	input wire logic [CELL_W-1:0] over_temp_fault,
	input wire logic [CELL_W-1:0] under_temp_fault,
	input wire logic [CELL_W-1:0] over_volt_fault,
	input wire logic [CELL_W-1:0] under_volt_fault,
	input wire logic [BYTE_W-1:0] system_fault,
	input wire logic [PWR_W-1:0]  power_rail_fault,
	// fault pin
	input wire logic              fault_output_pin_n
);
	logic [MSK_W-1:0] msk;  // shadow mask
	logic             wr_m; // mask write in data phase
	logic             rd_s; // summary read in data phase
	wire              pin  = !fault_output_pin_n;
	wire              take = hsel & htrans[1] & hready & (haddr[31:14] == 18'h0);
	wire  [11:0]      idx  = haddr[IDX_MSB:IDX_LSB];
	// shadow lands on the same edge as the real register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msk  <= MASK_RST;
			wr_m <= 1'b0;
			rd_s <= 1'b0;
		end else begin
			wr_m <= take & hwrite & (idx == IDX_MASK);
			rd_s <= take & !hwrite & (idx == IDX_SUMMARY);
			msk  <= wr_m ? hwdata[MSK_W-1:0] : msk;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// an unmasked source drives the pin low one edge later
	property p_comp; !msk[M_COMP] && (|adc_compare_fault) |=> pin; endproperty
	a_comp: assert property (p_comp) else $error("compare fault missed");
	property p_otp; !msk[M_OTP] && (|nvm_fault) |=> pin; endproperty
	a_otp: assert property (p_otp) else $error("nvm fault missed");
	property p_beat;
		(!msk[M_HB] && (|heartbeat_tone_status[1:0])) ||
		(!msk[M_TONE] && heartbeat_tone_status[H_TONE]) ||
		(!msk[M_UPSTRM] && heartbeat_tone_status[H_UPSTR]) |=> pin;
	endproperty
	a_beat: assert property (p_beat) else $error("heartbeat fault missed");
	property p_temp;
		(!msk[M_OT] && (|over_temp_fault)) || (!msk[M_UT] && (|under_temp_fault)) |=> pin;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature fault missed");
	property p_volt;
		(!msk[M_OV] && (|over_volt_fault)) || (!msk[M_UV] && (|under_volt_fault)) |=> pin;
	endproperty
	a_volt: assert property (p_volt) else $error("voltage fault missed");
	property p_sys; !msk[M_SYS] && (|system_fault) |=> pin; endproperty
	a_sys: assert property (p_sys) else $error("system fault missed");
	property p_pwr; !msk[M_PWR] && (|power_rail_fault) |=> pin; endproperty
	a_pwr: assert property (p_pwr) else $error("rail fault missed");
	// the summary read and the pin see the same edge
	property p_mirror; rd_s |-> ((hrdata[7:0] != 8'h00) == pin) && (hrdata[31:8] == 24'h0);
	endproperty
	a_mirror: assert property (p_mirror) else $error("summary and pin differ");
	c_read: cover property (rd_s && pin);
	c_mask: cover property (wr_m);
	c_beat: cover property (!msk[M_TONE] && heartbeat_tone_status[H_TONE]);
endmodule
bind fsus_top fsus_top_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .adc_compare_fault, .nvm_fault, .heartbeat_tone_status, .over_temp_fault,
	.under_temp_fault, .over_volt_fault, .under_volt_fault, .system_fault, .power_rail_fault,
	.fault_output_pin_n);

// ---- bench/fsus_top_test.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %0t: mismatch %h", $time, g); end end
module fsus_top_test
	import fsus_pkg::*;
;
	// fault sources in port order
	typedef struct packed {
		logic [PROT_W-1:0] prot;
		logic [COMP_W-1:0] comp;
		logic [BYTE_W-1:0] otp, chain;
		logic [HBT_W-1:0]  hbt;
		logic [CELL_W-1:0] ot, ut, ov, uv;
		logic [BYTE_W-1:0] sys;
		logic [PWR_W-1:0]  pwr;
	} fsus_src_t;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin_n, irq;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  ev;         // ping and wake above the five uart events
	fsus_mode_t  dev_mode;
	fsus_src_t   src;
	logic [31:0] lf = 32'd37; // generator state, fixed start
	int          n_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	fsus_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .prot_fault(src.prot),
		.adc_compare_fault(src.comp), .nvm_fault(src.otp), .chain_link_fault_status(src.chain),
		.heartbeat_tone_status(src.hbt), .over_temp_fault(src.ot), .under_temp_fault(src.ut),
		.over_volt_fault(src.ov), .under_volt_fault(src.uv), .system_fault(src.sys),
		.power_rail_fault(src.pwr), .tx_response_error(ev[4]), .rx_response_error(ev[3]),
		.rx_command_error(ev[2]), .link_clear_seen(ev[1]), .unexpected_stop_seen(ev[0]),
		.sleep_exit_ping(ev[5]), .wake_seen(ev[6]), .dev_mode, .fault_output_pin_n(pin_n), .irq);
	fsus_host_model i_host (.hclk, .hsel, .hwrite, .haddr, .htrans, .hsize, .hwdata,
		.hready(hreadyout), .hrdata);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// hang guard, well above the few hundred cycles needed
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict;
		end
	end
	// full new word per call so fields are not shifted copies
	function logic [31:0] rnd();
		repeat (32) lf = lf[0] ? (lf >> 1) ^ 32'h8020_0003 : lf >> 1;
		return lf;
	endfunction
	// expected summary byte from sources, masks and uart flags
	function automatic logic [7:0] exp_sum(fsus_src_t s, logic [MSK_W-1:0] m, logic [4:0] u);
		logic [7:0] e;
		e[S_PROT] = !m[M_PROT] && (|s.prot);
		e[S_COMP] = !m[M_COMP] && (|s.comp);
		e[S_OTP]  = !m[M_OTP] && (|s.otp);
		e[S_COMM] = (!m[M_UART] && (|u)) || (!m[M_CHAIN] && (|s.chain)) ||
			(!m[M_HB] && (|s.hbt[1:0])) || (!m[M_TONE] && s.hbt[H_TONE]) ||
			(!m[M_UPSTRM] && s.hbt[H_UPSTR]);
		e[S_TEMP] = (!m[M_OT] && (|s.ot)) || (!m[M_UT] && (|s.ut));
		e[S_VOLT] = (!m[M_OV] && (|s.ov)) || (!m[M_UV] && (|s.uv));
		e[S_SYS]  = !m[M_SYS] && (|s.sys);
		e[S_PWR]  = !m[M_PWR] && (|s.pwr);
		return e;
	endfunction
	// expected uart flags after one event pulse in a given mode
	function automatic logic [4:0] exp_uart(logic [6:0] e, fsus_mode_t md);
		logic [4:0] u;
		u = e[4:0];
		u[U_CLEAR] = u[U_CLEAR] | (e[5] && md != FSUS_SHUTDOWN) | (e[6] && md == FSUS_ACTIVE);
		u[U_STOP]  = u[U_STOP] | (e[5] && md == FSUS_ACTIVE);
		return u;
	endfunction
	task automatic rd(input logic [11:0] i);
		i_host.xfer(1'b0, i, WORD_RST, d);
	endtask
	task automatic wr(input logic [11:0] i, input logic [31:0] v);
		logic [31:0] x;
		i_host.xfer(1'b1, i, v, x);
	endtask
	// write, then let the registered irq settle
	task automatic wr_irq(input logic [11:0] i, input logic [31:0] v);
		wr(i, v);
		@(posedge hclk);
		#1;
	endtask
	task automatic pulse(input logic [6:0] e, input fsus_mode_t md);
		@(posedge hclk);
		ev       <= e;
		dev_mode <= md;
		@(posedge hclk);
		ev <= 7'h00;
	endtask
	task print_verdict;
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		logic [223:0]     t;
		logic [31:0]      k;
		logic [MSK_W-1:0] m;
		logic [4:0]       u;
		logic [11:0]      ro [6];
		ro = '{IDX_SUMMARY, IDX_UART, IDX_MASK, IDX_IRQ_STAT, IDX_IRQ_MASK, 12'h7ff};
		hresetn = 1'b0;
		src = '0;
		ev = 7'h00;
		dev_mode = FSUS_ACTIVE;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		// writes to read-only places are dropped; all reads start at zero
		wr(IDX_SUMMARY, 32'hffff_ffff);
		wr(IDX_UART, 32'hffff_ffff);
		foreach (ro[i]) begin
			rd(ro[i]);
			`CHK(d, WORD_RST)
			// bus answer is constant: always ready, always okay
			`CHK({hreadyout, hresp}, 2'b10)
		end
		// random masks and sparse random sources against the model
		for (int n = 0; n < 40; n++) begin
			for (int j = 0; j < 7; j++) t = {t[191:0], rnd()};
			k = rnd();
			m = k[31:18];
			wr(IDX_MASK, {18'h0, m});
			k = rnd();
			@(posedge hclk);
			src <= fsus_src_t'(t[$bits(fsus_src_t)-1:0]) & fsus_src_t'({{PROT_W{k[0]}},
				{COMP_W{k[1]}}, {BYTE_W{k[2]}}, {BYTE_W{k[3]}}, {HBT_W{k[4]}}, {CELL_W{k[5]}},
				{CELL_W{k[6]}}, {CELL_W{k[7]}}, {CELL_W{k[8]}}, {BYTE_W{k[9]}}, {PWR_W{k[10]}}});
			rd(IDX_SUMMARY);
			k = {24'h0, exp_sum(src, m, 5'h00)};
			`CHK(d[31:4], k[31:4])
			`CHK(d[3:0], k[3:0])
			// sources stood for several cycles, so the pin has caught up
			`CHK(pin_n, ~|k[7:0])
		end
		// every uart event in every power mode, cleared after each
		@(posedge hclk);
		src <= '0;
		wr(IDX_MASK, WORD_RST);
		for (int i = 0; i < 7; i++) begin
			for (int md = 0; md < 3; md++) begin
				pulse(7'(1 << i), fsus_mode_t'(md));
				u = exp_uart(7'(1 << i), fsus_mode_t'(md));
				rd(IDX_UART);
				`CHK(d[4:2], u[4:2])
				`CHK({d[31:5], d[1:0]}, {27'h0, u[1:0]})
				rd(IDX_SUMMARY);
				`CHK(d, {24'h0, exp_sum('0, MASK_RST, u)})
				wr(IDX_UART_CLR, 32'h0000_001f);
			end
		end
		// interrupt raised, masked, enabled again and cleared
		wr(IDX_IRQ_STAT, 32'h0000_003f);
		wr(IDX_IRQ_MASK, 32'h1 << U_TX);
		pulse(7'h10, FSUS_ACTIVE);
		@(posedge hclk);
		#1;
		`CHK(irq, 1'b1)
		rd(IDX_IRQ_STAT);
		`CHK(d, (32'h1 << U_TX) | (32'h1 << I_SUMM))
		wr_irq(IDX_IRQ_MASK, WORD_RST);
		`CHK(irq, 1'b0)
		wr_irq(IDX_IRQ_MASK, 32'h1 << U_TX);
		`CHK(irq, 1'b1)
		wr_irq(IDX_IRQ_STAT, 32'h1 << U_TX);
		`CHK(irq, 1'b0)
		print_verdict;
	end
endmodule
